//--- msc_device.sv
// Device end: sense latches, enable outputs, cascade ready handshake and register port.
// Assumes a receiver elsewhere pulses jk_pair_rx for each JK symbol pair it decodes.
//
// Functional notes
// - Reset clears every register to default.
// - Reset leaves mode bit zero, stop mode.
// - Far side holds reset long enough.
// - Sense bit sets after 160 ns assertion.
// - Sense bit sticks until control-bus clear.
// - Enable outputs follow their enable bits.
// - Start only when all ready released.
// - Release ready after cascade mode and JK.
// - Ready output is open drain only.
// - Unused cascade start tied to ground.
// - Unused cascade ready left unconnected.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "msc_params.svh"

module msc_device
    import msc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    msc_link_if.device link,
    input wire logic [`MSC_ADDR_W-1:0] reg_addr,
    input wire logic [`MSC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`MSC_DATA_W-1:0] reg_rdata,
    input wire logic jk_pair_rx,
    output logic run_mode,
    output logic cascade_started,
    output logic irq
);

    msc_data_t mode_q;
    msc_data_t user_io_q;
    msc_data_t irq_mask_q;
    msc_data_t rdata_q;
    logic [2:0] sense_q;
    logic [2:0] sense_d;
    logic [2:0] enable_q;
    logic [2:0] out_pin_q;
    wire logic [2:0] qual;
    logic ready_oe_q;
    logic irq_q;
    logic run_q;
    logic started_q;
    logic start_seen_q;
    msc_casc_state_t casc_q;
    msc_casc_state_t casc_d;

    function automatic logic hit(input msc_addr_t a, input msc_addr_t ofs);
        hit = (a == ofs);
    endfunction

    function automatic msc_data_t read_mux(input msc_addr_t a);
        msc_data_t v;
        v = '0;
        case (a)
            `MSC_OFS_MODE: begin
                v = mode_q;
            end
            `MSC_OFS_USER_IO: begin
                v = user_io_q;
            end
            `MSC_OFS_IRQ_MASK: begin
                v = irq_mask_q;
            end
            `MSC_OFS_CASC_STAT: begin
                v = {4'h0, start_seen_q, ready_oe_q, casc_q};
            end
            default: begin
                v = '0;
            end
        endcase
        read_mux = v;
    endfunction

    logic wr_mode;
    logic wr_uio;
    logic wr_mask;
    logic cm_bit;

    assign wr_mode = reg_wr && hit(reg_addr, `MSC_OFS_MODE);
    assign wr_uio = reg_wr && hit(reg_addr, `MSC_OFS_USER_IO);
    assign wr_mask = reg_wr && hit(reg_addr, `MSC_OFS_IRQ_MASK);
    assign cm_bit = mode_q[`MSC_MODE_CM_BIT];

    msc_sense_filter u_sense0 (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .sense_in(link.user_sense_pin0),
        .qualified(qual[0])
    );

    msc_sense_filter u_sense1 (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .sense_in(link.user_sense_pin1),
        .qualified(qual[1])
    );

    msc_sense_filter u_sense2 (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .sense_in(link.user_sense_pin2),
        .qualified(qual[2])
    );

    // Mode register: bit 0 run/stop, bit 1 cascade mode; other bits read as zero.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= `MSC_MODE_RESET;
        end else if (wr_mode) begin
            mode_q <= {6'h00, reg_wdata[`MSC_MODE_CM_BIT], reg_wdata[`MSC_MODE_RUN_BIT]};
        end
    end

    // Sense bits: a qualified input sets, a one written clears, and the set wins.
    always_comb begin
        sense_d = sense_q;
        if (wr_uio) begin
            sense_d = sense_d & ~reg_wdata[`MSC_UIO_SENSE_LSB +: 3];
        end
        sense_d = sense_d | qual;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sense_q <= 3'(`MSC_USER_IO_RESET >> `MSC_UIO_SENSE_LSB);
        end else begin
            sense_q <= sense_d;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_q <= 3'h0;
        end else if (wr_uio) begin
            enable_q <= reg_wdata[`MSC_UIO_ENABLE_LSB +: 3];
        end
    end

    // The pins track the enable bits one cycle later so they come from flops.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_pin_q <= 3'h0;
        end else begin
            out_pin_q <= enable_q;
        end
    end

    assign user_io_q = {1'b0, enable_q, 1'b0, sense_q};

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_q <= `MSC_IRQ_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_q <= {5'h00, reg_wdata[`MSC_UIO_SENSE_LSB +: 3]};
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(sense_d & irq_mask_q[2:0]);
        end
    end

    // Cascade sequencing. Clearing cascade mode drops back to idle from any state,
    // which pulls the shared ready line low again and holds off the other devices.
    always_comb begin
        casc_d = casc_q;
        case (casc_q)
            MSC_CASC_IDLE: begin
                if (cm_bit) begin
                    casc_d = MSC_CASC_WAIT_JK;
                end
            end
            MSC_CASC_WAIT_JK: begin
                if (!cm_bit) begin
                    casc_d = MSC_CASC_IDLE;
                end else if (jk_pair_rx) begin
                    casc_d = MSC_CASC_READY;
                end
            end
            MSC_CASC_READY: begin
                if (!cm_bit) begin
                    casc_d = MSC_CASC_IDLE;
                end else if (link.cascade_start) begin
                    casc_d = MSC_CASC_STARTED;
                end
            end
            MSC_CASC_STARTED: begin
                if (!cm_bit) begin
                    casc_d = MSC_CASC_IDLE;
                end
            end
            default: begin
                casc_d = MSC_CASC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            casc_q <= MSC_CASC_IDLE;
        end else begin
            casc_q <= casc_d;
        end
    end

    // Pull low until released; the line never drives high so devices can share it.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ready_oe_q <= 1'b1;
        end else begin
            ready_oe_q <= !(casc_d == MSC_CASC_READY || casc_d == MSC_CASC_STARTED);
        end
    end

    // Sticky record that a start arrived while released; cleared by leaving cascade mode.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            start_seen_q <= 1'b0;
        end else if (casc_q == MSC_CASC_READY && link.cascade_start) begin
            start_seen_q <= 1'b1;
        end else if (!cm_bit) begin
            start_seen_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_q <= 1'b0;
            started_q <= 1'b0;
        end else begin
            run_q <= mode_q[`MSC_MODE_RUN_BIT];
            started_q <= (casc_d == MSC_CASC_STARTED);
        end
    end

    // Unmapped addresses read as zero; the port never stalls.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            rdata_q <= read_mux(reg_addr);
        end else begin
            rdata_q <= '0;
        end
    end

    assign link.user_output_pin0 = out_pin_q[0];
    assign link.user_output_pin1 = out_pin_q[1];
    assign link.user_output_pin2 = out_pin_q[2];
    assign link.cascade_ready_out = 1'b0;
    assign link.cascade_ready_oe = ready_oe_q;
    assign reg_rdata = rdata_q;
    assign run_mode = run_q;
    assign cascade_started = started_q;
    assign irq = irq_q;

endmodule

//--- msc_host.sv
// External user logic end: drives sense pins, watches enable pins, issues cascade start.
// Assumes every device in the cascade shares the one ready wire.
`timescale 1ns/100ps
`include "msc_params.svh"

module msc_host
    import msc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    msc_link_if.host link,
    input wire logic [2:0] sense_req,
    output logic [2:0] enable_seen,
    input wire logic cascade_use,
    input wire logic all_cm_set,
    input wire logic start_req,
    output logic ready_released
);

    logic [2:0] sense_q;
    logic [2:0] enable_q;
    logic start_q;
    logic released_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sense_q <= 3'h0;
            enable_q <= 3'h0;
            released_q <= 1'b0;
        end else begin
            sense_q <= sense_req;
            enable_q <= {link.user_output_pin2, link.user_output_pin1, link.user_output_pin0};
            released_q <= link.cascade_ready_line;
        end
    end

    // Start is held at ground unless cascading is in use, all modes are set and the
    // shared ready wire has been seen released.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            start_q <= 1'b0;
        end else if (!cascade_use) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start_req && all_cm_set && released_q;
        end
    end

    assign link.user_sense_pin0 = sense_q[0];
    assign link.user_sense_pin1 = sense_q[1];
    assign link.user_sense_pin2 = sense_q[2];
    assign link.cascade_start = start_q;
    assign enable_seen = enable_q;
    assign ready_released = released_q;

endmodule

//--- msc_link_if.sv
// Pin-level link between the physical-layer device end and the external user logic end.
// Assumes a pull-up on the open-drain cascade ready wire.
`timescale 1ns/100ps

interface msc_link_if;
    logic user_sense_pin0;
    logic user_sense_pin1;
    logic user_sense_pin2;
    logic user_output_pin0;
    logic user_output_pin1;
    logic user_output_pin2;
    logic cascade_start;
    logic cascade_ready_out;
    logic cascade_ready_oe;
    logic cascade_ready_line;

    // The wire reads high unless the device pulls it low.
    assign cascade_ready_line = cascade_ready_oe ? cascade_ready_out : 1'b1;

    modport device (
        input user_sense_pin0,
        input user_sense_pin1,
        input user_sense_pin2,
        input cascade_start,
        output user_output_pin0,
        output user_output_pin1,
        output user_output_pin2,
        output cascade_ready_out,
        output cascade_ready_oe
    );

    modport host (
        output user_sense_pin0,
        output user_sense_pin1,
        output user_sense_pin2,
        output cascade_start,
        input user_output_pin0,
        input user_output_pin1,
        input user_output_pin2,
        input cascade_ready_line
    );
endinterface

//--- msc_link_monitor.sv
// Concurrent checks on the pins that join the device end and the user logic end.
// Assumes it is instantiated beside the link interface with its signals wired by name.
`timescale 1ns/100ps

module msc_link_monitor (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic user_sense_pin0,
    input wire logic user_sense_pin1,
    input wire logic user_sense_pin2,
    input wire logic user_output_pin0,
    input wire logic user_output_pin1,
    input wire logic user_output_pin2,
    input wire logic cascade_start,
    input wire logic cascade_ready_out,
    input wire logic cascade_ready_oe,
    input wire logic cascade_ready_line
);
    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_released;
        $fell(cascade_ready_oe);
    endsequence

    sequence s_start_rise;
        $rose(cascade_start);
    endsequence

    a_ready_drives_low: assert property (cascade_ready_out == 1'b0)
        else $error("cascade ready driven high");
    a_ready_line_wired: assert property (cascade_ready_line == !cascade_ready_oe)
        else $error("ready line does not follow the pull-down enable");
    a_reset_ready_held: assert property ($rose(arst_n) |-> cascade_ready_oe)
        else $error("ready line not held low out of reset");
    a_reset_outputs_low: assert property ($rose(arst_n) |->
        !(user_output_pin0 | user_output_pin1 | user_output_pin2))
        else $error("enable output high out of reset");
    a_reset_start_low: assert property ($rose(arst_n) |-> !cascade_start)
        else $error("cascade start high out of reset");
    a_start_after_release: assert property (s_start_rise |-> $past(cascade_ready_line, 2))
        else $error("cascade start raised before the ready line was released");
    a_start_while_released: assert property (s_start_rise |-> !cascade_ready_oe)
        else $error("cascade start raised while the ready line is pulled low");
    // Software never clears cascade mode within three cycles of a release here.
    a_release_holds: assert property (s_released |-> !cascade_ready_oe[*3])
        else $error("ready line pulled low again right after release");

    c_started: cover property (s_start_rise);
endmodule

//--- msc_params.svh
// Offsets, field positions, reset values and timing counts for the sense/enable/cascade block.
// Assumes a single 40 MHz system clock and an 8-bit register port with a 4-bit address.
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH

`define MSC_ADDR_W 4
`define MSC_DATA_W 8

`define MSC_OFS_MODE 4'h0
`define MSC_OFS_USER_IO 4'h1
`define MSC_OFS_IRQ_MASK 4'h2
`define MSC_OFS_CASC_STAT 4'h3

`define MSC_MODE_RUN_BIT 0
`define MSC_MODE_CM_BIT 1
`define MSC_MODE_RESET 8'h00
`define MSC_USER_IO_RESET 8'h00
`define MSC_IRQ_MASK_RESET 8'h00

`define MSC_UIO_SENSE_LSB 0
`define MSC_UIO_ENABLE_LSB 4

`define MSC_CLK_PERIOD_NS 25
`define MSC_SENSE_MIN_NS 160
`define MSC_SENSE_CYC ((`MSC_SENSE_MIN_NS + `MSC_CLK_PERIOD_NS - 1) / `MSC_CLK_PERIOD_NS)
`define MSC_SENSE_CNT_W 3

`endif

//--- msc_pkg.sv
// Types shared by both ends of the sense/enable/cascade block.
// Assumes msc_params.svh is compiled alongside.
`include "msc_params.svh"

package msc_pkg;

    typedef logic [`MSC_ADDR_W-1:0] msc_addr_t;
    typedef logic [`MSC_DATA_W-1:0] msc_data_t;

    // Gray coded along idle, waiting for JK, released, started.
    typedef enum logic [1:0] {
        MSC_CASC_IDLE = 2'h0,
        MSC_CASC_WAIT_JK = 2'h1,
        MSC_CASC_READY = 2'h3,
        MSC_CASC_STARTED = 2'h2
    } msc_casc_state_t;

endpackage

//--- msc_sense_filter.sv
// Synchroniser and minimum-width qualifier for one sense input.
// Assumes the input is active high and asynchronous to sys_clk.
`timescale 1ns/100ps
`include "msc_params.svh"

module msc_sense_filter
    import msc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic sense_in,
    output logic qualified
);

    localparam logic [`MSC_SENSE_CNT_W-1:0] HOLD_CYC = `MSC_SENSE_CNT_W'(`MSC_SENSE_CYC);

    logic meta_q;
    logic sync_q;
    logic [`MSC_SENSE_CNT_W-1:0] run_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= sense_in;
            sync_q <= meta_q;
        end
    end

    // Counts consecutive high samples; saturates so a long assertion keeps qualifying.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_q <= '0;
        end else if (!sync_q) begin
            run_q <= '0;
        end else if (run_q != HOLD_CYC) begin
            run_q <= run_q + `MSC_SENSE_CNT_W'(1);
        end
    end

    // Seven samples of 25 ns cover at least 160 ns. The sample now in sync_q is the
    // seventh, so six must already be counted; a 175 ns pulse qualifies, 150 ns does not.
    assign qualified = sync_q && (run_q >= HOLD_CYC - `MSC_SENSE_CNT_W'(1));

endmodule

//--- tb_misc_sense_enable_cascade.sv
// Self-checking bench: register port tasks drive the device end, pins are watched via the host.
// Assumes the device and host ends face each other across one link interface.
`timescale 1ns/100ps
`include "msc_params.svh"

module tb_misc_sense_enable_cascade
    import msc_pkg::*;
;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    msc_addr_t reg_addr = 4'h0;
    msc_data_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    msc_data_t reg_rdata;
    logic jk_pair_rx = 1'b0;
    logic run_mode;
    logic cascade_started;
    logic irq;
    logic [2:0] sense_req = 3'h0;
    logic [2:0] enable_seen;
    logic cascade_use = 1'b0;
    logic all_cm_set = 1'b0;
    logic start_req = 1'b0;
    logic ready_released;
    int err_total = 0;
    int checks = 0;
    int cyc_cnt = 0;
    logic [7:0] exp_v;

    always #12.5 sys_clk = ~sys_clk;

    msc_link_if msc_link_if_inst ();

    msc_device msc_device_inst (.sys_clk(sys_clk), .arst_n(arst_n), .link(msc_link_if_inst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .jk_pair_rx(jk_pair_rx), .run_mode(run_mode),
        .cascade_started(cascade_started), .irq(irq));

    msc_host msc_host_inst (.sys_clk(sys_clk), .arst_n(arst_n), .link(msc_link_if_inst),
        .sense_req(sense_req), .enable_seen(enable_seen), .cascade_use(cascade_use),
        .all_cm_set(all_cm_set), .start_req(start_req), .ready_released(ready_released));

    msc_link_monitor msc_link_monitor_inst (.sys_clk(sys_clk), .arst_n(arst_n),
        .user_sense_pin0(msc_link_if_inst.user_sense_pin0),
        .user_sense_pin1(msc_link_if_inst.user_sense_pin1),
        .user_sense_pin2(msc_link_if_inst.user_sense_pin2),
        .user_output_pin0(msc_link_if_inst.user_output_pin0),
        .user_output_pin1(msc_link_if_inst.user_output_pin1),
        .user_output_pin2(msc_link_if_inst.user_output_pin2),
        .cascade_start(msc_link_if_inst.cascade_start),
        .cascade_ready_out(msc_link_if_inst.cascade_ready_out),
        .cascade_ready_oe(msc_link_if_inst.cascade_ready_oe),
        .cascade_ready_line(msc_link_if_inst.cascade_ready_line));

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input msc_addr_t a, input msc_data_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rd(input msc_addr_t a, input msc_data_t exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    always @(posedge sys_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 4000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        cyc(20);
        arst_n <= 1'b1;
        rd(`MSC_OFS_MODE, `MSC_MODE_RESET);
        rd(`MSC_OFS_USER_IO, `MSC_USER_IO_RESET);
        rd(`MSC_OFS_IRQ_MASK, `MSC_IRQ_MASK_RESET);
        rd(`MSC_OFS_CASC_STAT, 8'h04);
        chk({7'h00, run_mode}, 8'h00);
        chk({7'h00, ready_released}, 8'h00);
        wr(`MSC_OFS_MODE, 8'h01);
        cyc(2);
        chk({7'h00, run_mode}, 8'h01);
        foreach (exp_v[i]) begin
            wr(`MSC_OFS_USER_IO, {1'b0, 3'(i), 4'h0});
            // Enable bit, device pin flop and host flop: the host sees it three edges on.
            cyc(3);
            chk({5'h00, enable_seen}, {5'h00, 3'(i)});
            rd(`MSC_OFS_USER_IO, {1'b0, 3'(i), 4'h0});
        end
        wr(`MSC_OFS_USER_IO, 8'h00);
        // A pulse one sample short of the qualifying width must be ignored.
        @(posedge sys_clk);
        sense_req <= 3'h1;
        cyc(6);
        sense_req <= 3'h0;
        cyc(12);
        rd(`MSC_OFS_USER_IO, 8'h00);
        exp_v = 8'h00;
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            sense_req <= 3'(1 << i);
            cyc(7);
            sense_req <= 3'h0;
            cyc(12);
            exp_v = exp_v | 8'(1 << i);
            rd(`MSC_OFS_USER_IO, exp_v);
        end
        wr(`MSC_OFS_USER_IO, 8'h00);
        rd(`MSC_OFS_USER_IO, 8'h07);
        chk({7'h00, irq}, 8'h00);
        wr(`MSC_OFS_IRQ_MASK, 8'h02);
        cyc(2);
        chk({7'h00, irq}, 8'h01);
        wr(`MSC_OFS_USER_IO, 8'h02);
        cyc(2);
        chk({7'h00, irq}, 8'h00);
        rd(`MSC_OFS_USER_IO, 8'h05);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        rd(`MSC_OFS_MODE, 8'h01);
        @(posedge sys_clk);
        cascade_use <= 1'b1;
        all_cm_set <= 1'b1;
        start_req <= 1'b1;
        @(posedge sys_clk);
        jk_pair_rx <= 1'b1;
        @(posedge sys_clk);
        jk_pair_rx <= 1'b0;
        cyc(4);
        chk({7'h00, ready_released}, 8'h00);
        wr(`MSC_OFS_MODE, 8'h03);
        rd(`MSC_OFS_CASC_STAT, 8'h05);
        chk({7'h00, ready_released}, 8'h00);
        @(posedge sys_clk);
        jk_pair_rx <= 1'b1;
        @(posedge sys_clk);
        jk_pair_rx <= 1'b0;
        cyc(6);
        chk({7'h00, ready_released}, 8'h01);
        chk({7'h00, cascade_started}, 8'h01);
        rd(`MSC_OFS_CASC_STAT, 8'h0A);
        wr(`MSC_OFS_MODE, 8'h01);
        cyc(4);
        chk({7'h00, ready_released}, 8'h00);
        chk({7'h00, cascade_started}, 8'h00);
        start_req <= 1'b0;
        wr(`MSC_OFS_USER_IO, 8'h70);
        cyc(3);
        arst_n <= 1'b0;
        cyc(3);
        chk({5'h00, enable_seen}, 8'h00);
        arst_n <= 1'b1;
        rd(`MSC_OFS_USER_IO, 8'h00);
        rd(`MSC_OFS_MODE, 8'h00);
        rd(`MSC_OFS_IRQ_MASK, 8'h00);
        print_verdict();
    end
endmodule
